/* File: rtl/diag_pkg.sv */
// shared constants, types and register map of the diagnostic monitor
package diag_pkg;

  // timing: conversion cycle period and system clock rate
  localparam int CLK_MHZ = 25;
  localparam int CONV_TIME_US = 100000;
  localparam int CONV_CYCLES = CONV_TIME_US * CLK_MHZ;

  // diagnostic page byte offsets
  localparam logic [7:0] ALARM_MASK_LO_ADDR = 8'hf8;
  localparam logic [7:0] ALARM_MASK_HI_ADDR = 8'hf9;
  localparam logic [7:0] WARN_MASK_LO_ADDR = 8'hfa;
  localparam logic [7:0] WARN_MASK_HI_ADDR = 8'hfb;
  localparam logic [7:0] ALARM_FLAG_LO_ADDR = 8'h70;
  localparam logic [7:0] ALARM_FLAG_HI_ADDR = 8'h71;
  localparam logic [7:0] WARN_FLAG_LO_ADDR = 8'h74;
  localparam logic [7:0] WARN_FLAG_HI_ADDR = 8'h75;

  // vendor page: temperature correction table
  localparam logic [7:0] LUT_BASE_ADDR = 8'h60;
  localparam logic [7:0] LUT_LAST_ADDR = 8'h86;
  localparam int LUT_ENTRIES = 39;
  localparam logic [5:0] LUT_LAST_IDX = 6'h26;
  localparam logic [7:0] LUT_RESET = 8'h00;

  // mask reset values and implemented bits of the high bytes
  localparam logic [7:0] MASK_LO_RESET = 8'h00;
  localparam logic [7:0] MASK_HI_RESET = 8'h40;
  localparam logic [7:0] MASK_HI_USED = 8'hc0;
  localparam int FLAG_COUNT = 10;

  // index breakpoints in whole degrees
  localparam logic signed [10:0] TEMP_LOW_DEG = -11'sh2d;
  localparam logic signed [10:0] TEMP_HIGH_DEG = 11'sh068;
  localparam logic signed [10:0] TEMP_FIRST_DEG = -11'sh2c;

  // converter resolutions in bits
  localparam logic [3:0] RES_TEMP_LO = 4'h8;
  localparam logic [3:0] RES_TEMP_HI = 4'h9;
  localparam logic [3:0] RES_BYTE = 4'h8;
  localparam logic [3:0] RES_RX = 4'hc;

  // aux source codes; 111 is unused and falls back to supply input
  localparam logic [2:0] AUX_SUPPLY = 3'h0;
  localparam logic [2:0] AUX_ANALOG_SUPPLY = 3'h1;
  localparam logic [2:0] AUX_BIAS_DRIVE = 3'h2;
  localparam logic [2:0] AUX_MOD_DRIVE = 3'h3;
  localparam logic [2:0] AUX_POWER_LOOP_DAC = 3'h4;
  localparam logic [2:0] AUX_MOD_DAC = 3'h5;
  localparam logic [2:0] AUX_FAULT_DAC = 3'h6;

  typedef enum logic [2:0] {
    CH_TEMP = 3'h0,
    CH_AUX = 3'h1,
    CH_BIAS = 3'h2,
    CH_PD = 3'h3,
    CH_RX = 3'h4
  } chan_type;

  typedef enum logic [2:0] {
    ST_WAIT = 3'b001,
    ST_START = 3'b010,
    ST_BUSY = 3'b100
  } seq_state_type;

  typedef struct packed {
    logic start;
    chan_type chan;
    logic [2:0] aux_sel;
    logic [3:0] bits;
    logic gain;
    logic ref_sel;
  } adc_req_type;

  typedef struct packed {
    logic [11:0] temp;
    logic [11:0] aux;
    logic [11:0] bias;
    logic [11:0] pd;
    logic [11:0] rx;
  } results_type;

endpackage

/* File: rtl/temp_correct.sv */
// table index and chip-to-case correction of the sensed temperature
module temp_correct (
  input wire logic signed [9:0] temp_half,
  input wire logic [7:0] entry,
  output logic [5:0] index,
  output logic signed [10:0] case_half
);

  logic signed [10:0] deg;
  logic signed [10:0] deg_off;

  // floor to whole degrees, offset so the first interval starts at zero
  assign deg = 11'(temp_half >>> 1);
  assign deg_off = deg - diag_pkg::TEMP_FIRST_DEG;

  // clamp at both ends, four-degree bins between
  always_comb begin
    if (deg <= diag_pkg::TEMP_LOW_DEG) begin
      index = 6'h00;
    end else if (deg >= diag_pkg::TEMP_HIGH_DEG) begin
      index = diag_pkg::LUT_LAST_IDX;
    end else begin
      index = 6'(deg_off[7:2]) + 6'h01;
    end
  end

  // entry is twice the difference, already in half-degree units
  assign case_half = 11'(temp_half) - 11'(signed'(entry));

endmodule

/* File: rtl/diag_monitor_irq_mask.sv */
// monitor sequencer, temperature correction and masked alarm interrupt
// Notes on behaviour
// - The five channels are converted in fixed order once per period.
// - In vendor mode the supply channel may be redirected to another node.
// - The aux select code routes the voltage channel to node 000 to 110.
// - Temperature takes 8 or 9 bits, rx power 12 and the rest 8 bits.
// - The photodiode gain bit shrinks range fourfold; ref picks gnd/supply.
// - A 39-byte table at vendor bytes 60h-86h corrects sensed temperature.
// - Each table entry is twice the chip-to-case difference, 0.5 deg/bit.
// - Entry 0 is -45 and below, 38 is 104 and up, four-degree bins between.
// - An unmasked condition sets its flag and irq; a masked one no irq.
// - Mask byte 248 holds the eight paired alarms, 249 bits 7:6 rx power.
// - Warning mask bytes 250 and 251 use the same bit order as alarms.
// - Mask bits reset to 0 except rx power low alarm and warning: 1.
// - Flags latch until read or transmit disable toggles, unless level.
module diag_monitor_irq_mask #(
  parameter int CONV_CYCLES = diag_pkg::CONV_CYCLES
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic reg_page,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic vendor_mode,
  input wire logic [2:0] aux_source_select,
  input wire logic temp_9bit,
  input wire logic pd_gain,
  input wire logic photodiode_reference_select,
  input wire logic alarm_nolatch,
  input wire logic warn_nolatch,
  input wire logic tx_disable_pin,
  input wire logic [9:0] alarm_cond,
  input wire logic [9:0] warn_cond,
  output diag_pkg::adc_req_type adc_req,
  input wire logic adc_done,
  input wire logic [11:0] adc_data,
  output diag_pkg::results_type results,
  output logic signed [10:0] case_temp,
  output logic irq
);

  // refuse a period too short for five conversions
  if (CONV_CYCLES < 16) begin : g_bad_period
    $error("CONV_CYCLES too small");
  end
  localparam int TW = $clog2(CONV_CYCLES);
  diag_pkg::seq_state_type state_r, state_nxt;
  diag_pkg::chan_type chan_r, chan_nxt;
  logic [TW-1:0] tick_cnt_r, tick_cnt_nxt;
  diag_pkg::adc_req_type adc_req_r, adc_req_nxt;
  diag_pkg::results_type res_r, res_nxt;
  logic [11:0] res_mask;

  // period timer runs free so the refresh rate never drifts with latency
  assign tick_cnt_nxt = (tick_cnt_r == TW'(CONV_CYCLES - 1)) ? '0 :
                        tick_cnt_r + TW'(1);

  // mask conversion data down to the channel's resolution
  assign res_mask = (adc_req_r.bits == diag_pkg::RES_RX) ? 12'hfff :
                    (adc_req_r.bits == diag_pkg::RES_TEMP_HI) ? 12'h1ff :
                    12'h0ff;

  // round robin: one request per channel, wait for done, next channel
  always_comb begin
    state_nxt = state_r;
    chan_nxt = chan_r;
    res_nxt = res_r;
    adc_req_nxt = adc_req_r;
    adc_req_nxt.start = 1'b0;
    unique case (state_r)
      diag_pkg::ST_WAIT: begin
        if (tick_cnt_r == '0) begin
          state_nxt = diag_pkg::ST_START;
          chan_nxt = diag_pkg::CH_TEMP;
        end
      end
      diag_pkg::ST_START: begin
        adc_req_nxt.start = 1'b1;
        adc_req_nxt.chan = chan_r;
        adc_req_nxt.gain = pd_gain;
        adc_req_nxt.ref_sel = photodiode_reference_select;
        adc_req_nxt.aux_sel = diag_pkg::AUX_SUPPLY;
        if (vendor_mode && aux_source_select <= diag_pkg::AUX_FAULT_DAC) begin
          adc_req_nxt.aux_sel = aux_source_select;
        end
        unique case (chan_r)
          diag_pkg::CH_TEMP: adc_req_nxt.bits = temp_9bit ?
            diag_pkg::RES_TEMP_HI : diag_pkg::RES_TEMP_LO;
          diag_pkg::CH_RX: adc_req_nxt.bits = diag_pkg::RES_RX;
          default: adc_req_nxt.bits = diag_pkg::RES_BYTE;
        endcase
        state_nxt = diag_pkg::ST_BUSY;
      end
      diag_pkg::ST_BUSY: begin
        if (adc_done) begin
          unique case (chan_r)
            diag_pkg::CH_TEMP: res_nxt.temp = adc_data & res_mask;
            diag_pkg::CH_AUX: res_nxt.aux = adc_data & res_mask;
            diag_pkg::CH_BIAS: res_nxt.bias = adc_data & res_mask;
            diag_pkg::CH_PD: res_nxt.pd = adc_data & res_mask;
            default: res_nxt.rx = adc_data & res_mask;
          endcase
          if (chan_r == diag_pkg::CH_RX) begin
            state_nxt = diag_pkg::ST_WAIT;
          end else begin
            chan_nxt = diag_pkg::chan_type'(chan_r + 3'h1);
            state_nxt = diag_pkg::ST_START;
          end
        end
      end
      default: state_nxt = diag_pkg::ST_WAIT;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_r <= diag_pkg::ST_WAIT;
      chan_r <= diag_pkg::CH_TEMP;
      tick_cnt_r <= '0;
      adc_req_r <= '0;
      res_r <= '0;
    end else begin
      state_r <= state_nxt;
      chan_r <= chan_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      adc_req_r <= adc_req_nxt;
      res_r <= res_nxt;
    end
  end

  logic [7:0] lut_mem [diag_pkg::LUT_ENTRIES];
  logic signed [9:0] temp_half;
  logic [5:0] lut_idx;
  logic signed [10:0] case_half;
  logic signed [10:0] case_temp_r;

  // 8-bit results are whole degrees, 9-bit ones half degrees
  assign temp_half = temp_9bit ? 10'(signed'(res_r.temp[8:0])) :
                     {res_r.temp[7], res_r.temp[7:0], 1'b0};

  temp_correct u_temp_correct (
    .temp_half(temp_half),
    .entry(lut_mem[lut_idx]),
    .index(lut_idx),
    .case_half(case_half)
  );

  // table bytes are written through the vendor page
  genvar gi;
  generate
    for (gi = 0; gi < diag_pkg::LUT_ENTRIES; gi++) begin : g_lut
      logic [7:0] lut_nxt;
      always_comb begin
        lut_nxt = lut_mem[gi];
        if (reg_wr && reg_page &&
            reg_addr == diag_pkg::LUT_BASE_ADDR + 8'(gi)) begin
          lut_nxt = reg_wdata;
        end
      end
      always_ff @(posedge sys_clk) begin
        if (srst) begin
          lut_mem[gi] <= diag_pkg::LUT_RESET;
        end else begin
          lut_mem[gi] <= lut_nxt;
        end
      end
    end
  endgenerate

  logic txd_s1_r, txd_s2_r, txd_s3_r, txd_stable_r, txd_stable_nxt;
  logic txd_toggle;

  // second and third stage must agree before a change is believed
  assign txd_toggle = (txd_s2_r == txd_s3_r) && (txd_s3_r != txd_stable_r);
  assign txd_stable_nxt = txd_toggle ? txd_s3_r : txd_stable_r;

  logic [7:0] amask_lo_r, amask_lo_nxt, amask_hi_r, amask_hi_nxt;
  logic [7:0] wmask_lo_r, wmask_lo_nxt, wmask_hi_r, wmask_hi_nxt;
  logic [9:0] aflag_r, aflag_nxt, wflag_r, wflag_nxt;
  logic [9:0] aclr, wclr, amask, wmask;
  logic [7:0] rdata_r, rdata_nxt;
  logic rvalid_r, irq_r, irq_nxt;
  logic diag_wr, diag_rd;

  assign diag_wr = reg_wr && !reg_page;
  assign diag_rd = reg_rd && !reg_page;
  assign amask = {amask_lo_r, amask_hi_r[7:6]};
  assign wmask = {wmask_lo_r, wmask_hi_r[7:6]};

  // a flag byte read or a disable toggle clears its flags
  always_comb begin
    aclr = {10{txd_toggle}};
    wclr = {10{txd_toggle}};
    if (diag_rd && reg_addr == diag_pkg::ALARM_FLAG_LO_ADDR) aclr[9:2] = '1;
    if (diag_rd && reg_addr == diag_pkg::ALARM_FLAG_HI_ADDR) aclr[1:0] = '1;
    if (diag_rd && reg_addr == diag_pkg::WARN_FLAG_LO_ADDR) wclr[9:2] = '1;
    if (diag_rd && reg_addr == diag_pkg::WARN_FLAG_HI_ADDR) wclr[1:0] = '1;
    // set wins over clear; non-latching flags simply track the condition
    aflag_nxt = alarm_nolatch ? alarm_cond :
                (aflag_r & ~aclr) | alarm_cond;
    wflag_nxt = warn_nolatch ? warn_cond :
                (wflag_r & ~wclr) | warn_cond;
    irq_nxt = |(aflag_nxt & ~amask) | |(wflag_nxt & ~wmask);
  end

  // mask writes; reserved low bits of the high bytes never store
  always_comb begin
    amask_lo_nxt = amask_lo_r;
    amask_hi_nxt = amask_hi_r;
    wmask_lo_nxt = wmask_lo_r;
    wmask_hi_nxt = wmask_hi_r;
    if (diag_wr) begin
      unique case (reg_addr)
        diag_pkg::ALARM_MASK_LO_ADDR: amask_lo_nxt = reg_wdata;
        diag_pkg::ALARM_MASK_HI_ADDR:
          amask_hi_nxt = reg_wdata & diag_pkg::MASK_HI_USED;
        diag_pkg::WARN_MASK_LO_ADDR: wmask_lo_nxt = reg_wdata;
        diag_pkg::WARN_MASK_HI_ADDR:
          wmask_hi_nxt = reg_wdata & diag_pkg::MASK_HI_USED;
        default: ;
      endcase
    end
  end

  // read data one cycle after the strobe; unmapped bytes read zero
  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_page) begin
      if (reg_addr >= diag_pkg::LUT_BASE_ADDR &&
          reg_addr <= diag_pkg::LUT_LAST_ADDR) begin
        rdata_nxt = lut_mem[6'(reg_addr - diag_pkg::LUT_BASE_ADDR)];
      end
    end else begin
      unique case (reg_addr)
        diag_pkg::ALARM_MASK_LO_ADDR: rdata_nxt = amask_lo_r;
        diag_pkg::ALARM_MASK_HI_ADDR: rdata_nxt = amask_hi_r;
        diag_pkg::WARN_MASK_LO_ADDR: rdata_nxt = wmask_lo_r;
        diag_pkg::WARN_MASK_HI_ADDR: rdata_nxt = wmask_hi_r;
        diag_pkg::ALARM_FLAG_LO_ADDR: rdata_nxt = aflag_r[9:2];
        diag_pkg::ALARM_FLAG_HI_ADDR: rdata_nxt = {aflag_r[1:0], 6'h00};
        diag_pkg::WARN_FLAG_LO_ADDR: rdata_nxt = wflag_r[9:2];
        diag_pkg::WARN_FLAG_HI_ADDR: rdata_nxt = {wflag_r[1:0], 6'h00};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      amask_lo_r <= diag_pkg::MASK_LO_RESET;
      amask_hi_r <= diag_pkg::MASK_HI_RESET;
      wmask_lo_r <= diag_pkg::MASK_LO_RESET;
      wmask_hi_r <= diag_pkg::MASK_HI_RESET;
      aflag_r <= '0;
      wflag_r <= '0;
      irq_r <= 1'b0;
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
      case_temp_r <= '0;
      txd_s1_r <= 1'b0;
      txd_s2_r <= 1'b0;
      txd_s3_r <= 1'b0;
      txd_stable_r <= 1'b0;
    end else begin
      amask_lo_r <= amask_lo_nxt;
      amask_hi_r <= amask_hi_nxt;
      wmask_lo_r <= wmask_lo_nxt;
      wmask_hi_r <= wmask_hi_nxt;
      aflag_r <= aflag_nxt;
      wflag_r <= wflag_nxt;
      irq_r <= irq_nxt;
      rdata_r <= reg_rd ? rdata_nxt : rdata_r;
      rvalid_r <= reg_rd;
      case_temp_r <= case_half;
      txd_s1_r <= tx_disable_pin; // pin crosses in, three stages
      txd_s2_r <= txd_s1_r;
      txd_s3_r <= txd_s2_r;
      txd_stable_r <= txd_stable_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;
  assign adc_req = adc_req_r;
  assign results = res_r;
  assign case_temp = case_temp_r;
  assign irq = irq_r;
endmodule

/* File: tb/adc_model.sv */
// converter model answering the block's conversion requests
module adc_model (
  input wire logic sys_clk,
  input wire logic srst,
  input wire diag_pkg::adc_req_type adc_req,
  input wire logic slow,
  input wire logic [11:0] sample,
  output logic adc_done,
  output logic [11:0] adc_data
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;

  // one result per request; data toggles outside done so it is never held
  always @(posedge sys_clk) begin
    adc_done <= 1'b0;
    adc_data <= ~adc_data;
    if (srst) begin
      cnt <= 0;
      adc_data <= 12'h5a5;
    end else if (adc_req.start) begin
      cnt <= slow ? 8 : 2;
    end else if (cnt == 1) begin
      cnt <= 0;
      adc_done <= 1'b1;
      adc_data <= sample;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule

/* File: tb/diag_monitor.sv */
// concurrent checks on the diagnostic monitor ports
module diag_checker #(
  parameter int CONV_CYCLES = diag_pkg::CONV_CYCLES
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic reg_rvalid,
  input wire logic vendor_mode,
  input wire logic [2:0] aux_source_select,
  input wire logic temp_9bit,
  input wire logic pd_gain,
  input wire logic photodiode_reference_select,
  input wire logic [9:0] alarm_cond,
  input wire logic [9:0] warn_cond,
  input wire diag_pkg::adc_req_type adc_req,
  input wire logic adc_done,
  input wire logic [11:0] adc_data,
  input wire diag_pkg::results_type results,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  a_read_answer:
    assert property (reg_rd |=> reg_rvalid) else $error("read unanswered");
  a_irq_cause:
    assert property ($rose(irq) |-> $past(|{alarm_cond, warn_cond, reg_wr}))
    else $error("irq rose without cause");
  a_start_single:
    assert property (adc_req.start |=> !adc_req.start)
    else $error("start too long");
  a_next_chan:
    assert property (adc_done && adc_req.chan != diag_pkg::CH_RX |->
      ##2 adc_req.start) else $error("next channel late");
  a_chan_order:
    assert property (adc_req.start && adc_req.chan != diag_pkg::CH_TEMP |->
      adc_req.chan == $past(adc_req.chan) + 3'h1) else $error("bad order");
  a_bits_rx:
    assert property (adc_req.start && adc_req.chan == diag_pkg::CH_RX |->
      adc_req.bits == diag_pkg::RES_RX) else $error("rx width wrong");
  a_bits_temp:
    assert property (adc_req.start && adc_req.chan == diag_pkg::CH_TEMP |->
      adc_req.bits == ($past(temp_9bit) ? diag_pkg::RES_TEMP_HI :
      diag_pkg::RES_TEMP_LO)) else $error("temp width wrong");
  a_aux_route:
    assert property (adc_req.start && adc_req.chan == diag_pkg::CH_AUX |->
      adc_req.aux_sel == (($past(vendor_mode) &&
      $past(aux_source_select) != 3'h7) ? $past(aux_source_select) :
      diag_pkg::AUX_SUPPLY)) else $error("aux route wrong");
  a_pd_pass:
    assert property (adc_req.start && adc_req.chan == diag_pkg::CH_PD |->
      adc_req.gain == $past(pd_gain) &&
      adc_req.ref_sel == $past(photodiode_reference_select))
    else $error("photodiode setup wrong");
  a_rx_result:
    assert property (adc_done && adc_req.chan == diag_pkg::CH_RX |=>
      results.rx == $past(adc_data)) else $error("rx result wrong");

  // main scenarios reached
  cover property (irq);
  cover property (adc_req.start && adc_req.chan == diag_pkg::CH_RX);
  cover property (reg_rvalid);
endmodule

bind diag_monitor_irq_mask diag_checker #(.CONV_CYCLES(CONV_CYCLES)) chk (
  .sys_clk(sys_clk), .srst(srst), .reg_rd(reg_rd), .reg_wr(reg_wr),
  .reg_rvalid(reg_rvalid), .vendor_mode(vendor_mode),
  .aux_source_select(aux_source_select), .temp_9bit(temp_9bit),
  .pd_gain(pd_gain),
  .photodiode_reference_select(photodiode_reference_select),
  .alarm_cond(alarm_cond), .warn_cond(warn_cond), .adc_req(adc_req),
  .adc_done(adc_done), .adc_data(adc_data), .results(results), .irq(irq)
);

/* File: tb/testbench.sv */
// self-checking bench: masks, flags, sequencing and temperature correction
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CONV = 64;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic reg_page = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, reg_rvalid;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, lfsr = 8'h4b;
  logic vendor_mode = 1'b0, temp_9bit = 1'b0, pd_gain = 1'b0, pd_ref = 1'b0;
  logic alarm_nolatch = 1'b0, warn_nolatch = 1'b0, txd = 1'b0, slow = 1'b0;
  logic adc_done, irq;
  logic [2:0] aux_sel = 3'h7;
  logic [9:0] alarm_cond = 10'h000, warn_cond = 10'h000;
  logic [11:0] adc_data, sample = 12'h000;
  logic signed [10:0] case_temp;
  diag_pkg::adc_req_type adc_req;
  diag_pkg::results_type results;
  int n_mismatch = 0, tests_run = 0, n_done = 0;
  logic [7:0] lut [39];

  always #20 sys_clk = ~sys_clk;

  diag_monitor_irq_mask #(.CONV_CYCLES(CONV)) dut (
    .sys_clk(sys_clk), .srst(srst), .reg_page(reg_page),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .vendor_mode(vendor_mode), .aux_source_select(aux_sel),
    .temp_9bit(temp_9bit), .pd_gain(pd_gain),
    .photodiode_reference_select(pd_ref), .alarm_nolatch(alarm_nolatch),
    .warn_nolatch(warn_nolatch), .tx_disable_pin(txd),
    .alarm_cond(alarm_cond), .warn_cond(warn_cond), .adc_req(adc_req),
    .adc_done(adc_done), .adc_data(adc_data), .results(results),
    .case_temp(case_temp), .irq(irq)
  );

  adc_model adc (
    .sys_clk(sys_clk), .srst(srst), .adc_req(adc_req), .slow(slow),
    .sample(sample), .adc_done(adc_done), .adc_data(adc_data)
  );

  // count results so sequence ends are known without reading the block
  always @(posedge sys_clk) n_done <= srst ? 0 : n_done + int'(adc_done);

  function automatic logic [7:0] next_rand();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction

  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic pg, input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_page = pg;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    d = reg_rvalid ? reg_rdata : 8'hxx;
  endtask

  // bounded wait for the end of the channel sequence in progress, or of the next one if idle
  task automatic seq_end();
    int tgt;
    tgt = (n_done / 5 + 1) * 5;
    repeat (400) if (n_done < tgt) @(negedge sys_clk);
    repeat (3) @(negedge sys_clk);
  endtask

  // config only changes while idle, then one whole sequence is judged
  task automatic conv_test(input int t, input logic t9);
    logic [7:0] r;
    int idx;
    seq_end();
    r = next_rand();
    aux_sel = aux_sel + 3'h1;
    if (aux_sel == 3'h0) vendor_mode = ~vendor_mode;
    temp_9bit = t9;
    pd_gain = r[4];
    pd_ref = r[5];
    slow = r[6];
    sample = {r[3:0], t[7:0]};
    seq_end();
    chk(results.temp, sample & (t9 ? 12'h1ff : 12'h0ff));
    chk(results.aux, sample & 12'h0ff);
    chk(results.bias, sample & 12'h0ff);
    chk(results.pd, sample & 12'h0ff);
    chk(results.rx, sample);
    if (!t9) begin
      idx = t <= -45 ? 0 : t >= 104 ? 38 : (t + 44) / 4 + 1;
      chk({case_temp[10], case_temp}, 12'(2 * t - $signed(lut[idx])));
    end
  endtask

  // one flag raised with its mask set or clear, then read back
  task automatic flag_test(input int k, input logic w, input logic m);
    logic [7:0] d;
    logic [15:0] mk;
    mk = m ? 16'h0001 << (k < 2 ? k + 14 : k - 2) : 16'h0000;
    wr(1'b0, w ? 8'hfa : 8'hf8, mk[7:0]);
    wr(1'b0, w ? 8'hfb : 8'hf9, mk[15:8]);
    @(negedge sys_clk);
    if (w) warn_cond[k] = 1'b1;
    else alarm_cond[k] = 1'b1;
    @(negedge sys_clk);
    alarm_cond = 10'h000;
    warn_cond = 10'h000;
    chk({11'h000, irq}, {11'h000, ~m});
    rd((w ? 8'h74 : 8'h70) + (k < 2 ? 8'h01 : 8'h00), d);
    chk({4'h0, d}, 12'h001 << (k < 2 ? k + 6 : k - 2));
    @(negedge sys_clk);
    chk({11'h000, irq}, 12'h000);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    logic [7:0] d;
    int temps [8];
    temps = '{-128, -45, -44, -41, -40, 103, 104, 127};
    repeat (10) @(negedge sys_clk);
    srst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd(8'hf8 + 8'(i), d);
      chk({4'h0, d}, i[0] ? 12'h040 : 12'h000);
    end
    wr(1'b0, 8'hf9, 8'hff);
    rd(8'hf9, d);
    chk({4'h0, d}, 12'h0c0);
    wr(1'b0, 8'hfb, 8'h3f);
    rd(8'hfb, d);
    chk({4'h0, d}, 12'h000);
    rd(8'h80, d);
    chk({4'h0, d}, 12'h000);
    for (int k = 0; k < 10; k++) begin
      for (int j = 0; j < 4; j++) flag_test(k, j[0], j[1]);
    end
    // level mode tracks the condition with no read
    alarm_nolatch = 1'b1;
    alarm_cond[8] = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk({11'h000, irq}, 12'h001);
    alarm_cond = 10'h000;
    repeat (2) @(negedge sys_clk);
    chk({11'h000, irq}, 12'h000);
    alarm_nolatch = 1'b0;
    // latched flag cleared by a transmit disable toggle
    alarm_cond[5] = 1'b1;
    @(negedge sys_clk);
    alarm_cond = 10'h000;
    repeat (3) @(negedge sys_clk);
    chk({11'h000, irq}, 12'h001);
    txd = 1'b1;
    repeat (8) @(negedge sys_clk);
    chk({11'h000, irq}, 12'h000);
    for (int i = 0; i < 39; i++) begin
      lut[i] = next_rand();
      wr(1'b1, 8'h60 + 8'(i), lut[i]);
    end
    // page still selects the table, so the last entry reads back
    rd(8'h86, d);
    chk({4'h0, d}, {4'h0, lut[38]});
    foreach (temps[i]) conv_test(temps[i], 1'b0);
    conv_test(50, 1'b1);
    for (int i = 0; i < 4; i++) conv_test(int'($signed(next_rand())), 1'b0);
    complete_run();
  end

  // hang guard, several times the expected run length
  initial begin
    #(40 * 20000);
    n_mismatch++;
    complete_run();
  end
endmodule
